// [pkg/sbt_pkg.sv]
/*
  Constants shared by the sixteen-bit timer: register byte offsets,
  field positions, mode and event codes, and reset values.
  Assumes a 32-bit APB register bus with word-aligned registers.
*/
package sbt_pkg;

  // register byte offsets; per-half registers sit one word apart
  localparam logic [11:0] OFS_CFG     = 12'h000;
  localparam logic [11:0] OFS_MODE    = 12'h004;
  localparam logic [11:0] OFS_CTL     = 12'h00c;
  localparam logic [11:0] OFS_IMR     = 12'h010;
  localparam logic [11:0] OFS_RIS     = 12'h014;
  localparam logic [11:0] OFS_MIS     = 12'h018;
  localparam logic [11:0] OFS_ICR     = 12'h01c;
  localparam logic [11:0] OFS_ILR     = 12'h020;
  localparam logic [11:0] OFS_MATCH   = 12'h028;
  localparam logic [11:0] OFS_PRE     = 12'h030;
  localparam logic [11:0] OFS_VAL     = 12'h038;
  localparam logic [11:0] HALF_STRIDE = 12'h004;

  // configuration value for two independent halves
  localparam logic [2:0] CFG_HALVES = 3'h4;

  // half mode register fields
  localparam int MR_CMR = 2;
  localparam int MR_AMS = 3;
  localparam logic [1:0] MODE_ONESHOT  = 2'h1;
  localparam logic [1:0] MODE_PERIODIC = 2'h2;
  localparam logic [1:0] MODE_CAPTURE  = 2'h3;

  // control register fields, one byte per half
  localparam int CTL_STRIDE = 8;
  localparam int CTL_EN     = 0;
  localparam int CTL_STALL  = 1;
  localparam int CTL_EVT    = 2;
  localparam int CTL_OTE    = 5;
  localparam int CTL_PWML   = 6;

  // edge selection codes
  localparam logic [1:0] EVT_RISE = 2'h0;
  localparam logic [1:0] EVT_FALL = 2'h1;
  localparam logic [1:0] EVT_RSVD = 2'h2;
  localparam logic [1:0] EVT_BOTH = 2'h3;

  // status / mask / clear bit layout, one nibble per half
  localparam int IRQ_STRIDE = 4;
  localparam int IRQ_TO     = 0;
  localparam int IRQ_MATCH  = 1;
  localparam int IRQ_CAP    = 2;

  // reset values and counter constants
  localparam logic [15:0] ILR_RST = 16'hffff;
  localparam logic [7:0]  PRE_RST = 8'h00;
  localparam logic [15:0] CNT_ZERO = 16'h0000;
  localparam logic [15:0] CNT_STEP = 16'h0001;
  localparam logic [7:0]  PSC_ZERO = 8'h00;
  localparam logic [7:0]  PSC_STEP = 8'h01;

endpackage

// [core/sbt_timer.sv]
/*
  Sixteen-bit dual-half timer with APB register slave. Each half runs
  one-shot/periodic down-counting with prescaler, edge counting, edge
  timing with capture, or simple PWM on its capture/compare pin.
  Assumes one 50 MHz clock and an APB master; pin inputs are async.
*/
// The register offsets and the APB register port are this design's own decisions.
// What this block does
// - config value 0x4 splits into two halves
// - halves count down, optional 8-bit prescaler
// - mode field picks one-shot or periodic
// - mode 0x1 one-shot, 0x2 periodic
// - enable starts counting from held value
// - reload interval and prescale after zero
// - one-shot stops and clears enable; periodic continues
// - sticky time-out flag, masked flag, interrupt
// - trigger pulse only when trigger enabled
// - interval write loads counter next cycle
// - stall bit freezes the count
// - decrement every prescale plus one clocks
// - no prescaler in edge or PWM modes
// - edge count mode counts selected edges down
// - each edge decrements; match sets match flag
// - after match reload, disable, ignore edges
// - edge time free-runs from interval, one edge
// - selected edge captures count, sets capture flag
// - edge time keeps running, reloads at zero
// - PWM selected by alternate, capture, mode bits
// - PWM reloads at zero, raises no flags
// - PWM high at start, low at match, invertible
`timescale 1ns/1ns
module sbt_timer #(
  parameter int ADDR_W = 12
) (
  input  wire logic              clk_i,
  input  wire logic              rst_n_i,
  input  wire logic              psel_i,
  input  wire logic              penable_i,
  input  wire logic              pwrite_i,
  input  wire logic [ADDR_W-1:0] paddr_i,
  input  wire logic [31:0]       pwdata_i,
  output      logic [31:0]       prdata_o,
  output      logic              pready_o,
  output      logic              pslverr_o,
  input  wire logic [1:0]        ccp_i,
  output      logic [1:0]        ccp_o,
  output      logic [1:0]        ccp_oe_o,
  output      logic [1:0]        trig_o,
  output      logic              irq_o
);

  if (ADDR_W < 12) begin : g_chk
    $error("sbt_timer: ADDR_W must be at least 12");
  end

  typedef struct packed {
    logic [2:0]       cfg;
    logic [1:0][3:0]  mode;
    logic [15:0]      ctl;
    logic [7:0]       imr;
    logic [7:0]       ris;
    logic [1:0][15:0] ilr;
    logic [1:0][15:0] mat;
    logic [1:0][15:0] cnt;
    logic [1:0][15:0] cap;
    logic [1:0][7:0]  pre;
    logic [1:0][7:0]  psc;
    logic [1:0]       pwm;
    logic [1:0]       trig;
    logic [1:0]       s1;
    logic [1:0]       s2;
    logic [1:0]       s3;
    logic [1:0]       lvl;
    logic [31:0]      prdata;
    logic             pslverr;
  } sbt_state_s;

  sbt_state_s r_r;
  sbt_state_s r_nxt;

  logic [1:0] to_ev;
  logic [1:0] cap_ev;
  logic [1:0] ilr_wr;
  logic [1:0] pwm_m;
  logic [11:0] addr;

  assign addr = paddr_i[11:0];

  // next-state: bus, pin synchronisers, both halves, read mux
  always_comb begin
    logic        wr;
    logic [7:0]  clr;
    logic [7:0]  set;
    logic [1:0]  rise;
    logic [1:0]  fall;
    logic        hit;
    logic [31:0] rdat;
    logic [11:0] ofs;
    int          cb;
    int          ib;
    logic        en;
    logic        run;
    logic [3:0]  m;
    logic        per_m;
    logic        cnt_m;
    logic        tim_m;
    logic [1:0]  evt;
    logic        q;
    logic [15:0] dec;
    r_nxt = r_r;
    r_nxt.trig = '0;
    to_ev = '0;
    cap_ev = '0;
    ilr_wr = '0;
    pwm_m = '0;
    wr = psel_i & penable_i & pwrite_i;
    clr = '0;
    set = '0;
    rise = '0;
    fall = '0;
    hit = 1'b0;
    rdat = '0;
    ofs = '0;
    cb = 0;
    ib = 0;
    en = 1'b0;
    run = 1'b0;
    m = '0;
    per_m = 1'b0;
    cnt_m = 1'b0;
    tim_m = 1'b0;
    evt = '0;
    q = 1'b0;
    dec = '0;

    // three-stage pin sync; a level counts once stages two and three agree
    r_nxt.s1 = ccp_i;
    r_nxt.s2 = r_r.s1;
    r_nxt.s3 = r_r.s2;
    for (int n = 0; n < 2; n++) begin
      if (r_r.s2[n] == r_r.s3[n] && r_r.s3[n] != r_r.lvl[n]) begin
        r_nxt.lvl[n] = r_r.s3[n];
        rise[n] = r_r.s3[n];
        fall[n] = ~r_r.s3[n];
      end
    end

    // register writes take effect in the access phase
    if (wr) begin
      case (addr)
        sbt_pkg::OFS_CFG: r_nxt.cfg = pwdata_i[2:0];
        sbt_pkg::OFS_CTL: r_nxt.ctl = pwdata_i[15:0];
        sbt_pkg::OFS_IMR: r_nxt.imr = pwdata_i[7:0];
        sbt_pkg::OFS_ICR: clr = pwdata_i[7:0];
        default: ;
      endcase
      for (int n = 0; n < 2; n++) begin
        ofs = 12'(n) * sbt_pkg::HALF_STRIDE;
        if (addr == sbt_pkg::OFS_MODE + ofs) begin
          r_nxt.mode[n] = pwdata_i[3:0];
        end
        if (addr == sbt_pkg::OFS_ILR + ofs) begin
          r_nxt.ilr[n] = pwdata_i[15:0];
          r_nxt.cnt[n] = pwdata_i[15:0];
          ilr_wr[n] = 1'b1;
        end
        if (addr == sbt_pkg::OFS_MATCH + ofs) begin
          r_nxt.mat[n] = pwdata_i[15:0];
        end
        if (addr == sbt_pkg::OFS_PRE + ofs) begin
          r_nxt.pre[n] = pwdata_i[7:0];
        end
      end
    end

    // per-half counting; hardware enable clear overrides a same-cycle write
    for (int n = 0; n < 2; n++) begin
      cb = n * sbt_pkg::CTL_STRIDE;
      ib = n * sbt_pkg::IRQ_STRIDE;
      m = r_r.mode[n];
      en = r_r.ctl[cb + sbt_pkg::CTL_EN];
      run = (r_r.cfg == sbt_pkg::CFG_HALVES) & en
            & ~r_r.ctl[cb + sbt_pkg::CTL_STALL];
      pwm_m[n] = m[sbt_pkg::MR_AMS] & ~m[sbt_pkg::MR_CMR]
                 & (m[1:0] == sbt_pkg::MODE_PERIODIC);
      per_m = ~m[sbt_pkg::MR_AMS] & ~m[sbt_pkg::MR_CMR]
              & (m[1:0] == sbt_pkg::MODE_ONESHOT
                 | m[1:0] == sbt_pkg::MODE_PERIODIC);
      cnt_m = ~m[sbt_pkg::MR_CMR]
              & (m[1:0] == sbt_pkg::MODE_CAPTURE);
      tim_m = m[sbt_pkg::MR_CMR]
              & (m[1:0] == sbt_pkg::MODE_CAPTURE);
      evt = r_r.ctl[cb + sbt_pkg::CTL_EVT +: 2];
      // reserved code counts nothing; timing mode never takes both edges
      if (cnt_m) begin
        case (evt)
          sbt_pkg::EVT_RISE: q = rise[n];
          sbt_pkg::EVT_FALL: q = fall[n];
          sbt_pkg::EVT_BOTH: q = rise[n] | fall[n];
          default:           q = 1'b0;
        endcase
      end else begin
        q = (evt == sbt_pkg::EVT_FALL) ? fall[n]
            : (evt != sbt_pkg::EVT_RSVD) & rise[n];
      end

      if (run && !ilr_wr[n]) begin
        if (per_m) begin
          if (r_r.cnt[n] == sbt_pkg::CNT_ZERO) begin
            r_nxt.cnt[n] = r_r.ilr[n];
            r_nxt.psc[n] = r_r.pre[n];
            to_ev[n] = 1'b1;
            if (m[1:0] == sbt_pkg::MODE_ONESHOT) begin
              r_nxt.ctl[cb + sbt_pkg::CTL_EN] = 1'b0;
            end
          end else if (r_r.psc[n] == sbt_pkg::PSC_ZERO) begin
            r_nxt.psc[n] = r_r.pre[n];
            r_nxt.cnt[n] = r_r.cnt[n] - sbt_pkg::CNT_STEP;
          end else begin
            r_nxt.psc[n] = r_r.psc[n] - sbt_pkg::PSC_STEP;
          end
        end else if (pwm_m[n] || tim_m) begin
          // prescaler bypassed here, one step per clock
          r_nxt.cnt[n] = (r_r.cnt[n] == sbt_pkg::CNT_ZERO)
                         ? r_r.ilr[n]
                         : r_r.cnt[n] - sbt_pkg::CNT_STEP;
        end else if (cnt_m && q) begin
          dec = r_r.cnt[n] - sbt_pkg::CNT_STEP;
          if (dec == r_r.mat[n]) begin
            set[ib + sbt_pkg::IRQ_MATCH] = 1'b1;
            r_nxt.cnt[n] = r_r.ilr[n];
            r_nxt.ctl[cb + sbt_pkg::CTL_EN] = 1'b0;
          end else begin
            r_nxt.cnt[n] = dec;
          end
        end
        if (tim_m && q) begin
          r_nxt.cap[n] = r_r.cnt[n];
          cap_ev[n] = 1'b1;
        end
        if (pwm_m[n]) begin
          if (r_r.cnt[n] == r_r.ilr[n]) begin
            r_nxt.pwm[n] = 1'b1;
          end else if (r_r.cnt[n] == r_r.mat[n]) begin
            r_nxt.pwm[n] = 1'b0;
          end
        end
      end
      set[ib + sbt_pkg::IRQ_TO] = to_ev[n];
      set[ib + sbt_pkg::IRQ_CAP] = cap_ev[n];
      r_nxt.trig[n] = to_ev[n] & r_r.ctl[cb + sbt_pkg::CTL_OTE];
    end

    // sticky status: a same-cycle event beats the clear
    r_nxt.ris = (r_r.ris & ~clr) | set;

    // read data is sampled in the setup phase, one cycle before access
    if (psel_i && !penable_i) begin
      hit = 1'b1;
      case (addr)
        sbt_pkg::OFS_CFG: rdat = {29'h0, r_r.cfg};
        sbt_pkg::OFS_CTL: rdat = {16'h0, r_r.ctl};
        sbt_pkg::OFS_IMR: rdat = {24'h0, r_r.imr};
        sbt_pkg::OFS_RIS: rdat = {24'h0, r_r.ris};
        sbt_pkg::OFS_MIS: rdat = {24'h0, r_r.ris & r_r.imr};
        sbt_pkg::OFS_ICR: rdat = '0;
        default:          hit = 1'b0;
      endcase
      for (int n = 0; n < 2; n++) begin
        ofs = 12'(n) * sbt_pkg::HALF_STRIDE;
        m = r_r.mode[n];
        if (addr == sbt_pkg::OFS_MODE + ofs) begin
          rdat = {28'h0, m};
          hit = 1'b1;
        end
        if (addr == sbt_pkg::OFS_ILR + ofs) begin
          rdat = {16'h0, r_r.ilr[n]};
          hit = 1'b1;
        end
        if (addr == sbt_pkg::OFS_MATCH + ofs) begin
          rdat = {16'h0, r_r.mat[n]};
          hit = 1'b1;
        end
        if (addr == sbt_pkg::OFS_PRE + ofs) begin
          rdat = {24'h0, r_r.pre[n]};
          hit = 1'b1;
        end
        if (addr == sbt_pkg::OFS_VAL + ofs) begin
          // capture register in edge-time mode, live count otherwise
          rdat = (m[sbt_pkg::MR_CMR] && m[1:0] == sbt_pkg::MODE_CAPTURE)
                 ? {16'h0, r_r.cap[n]} : {16'h0, r_r.cnt[n]};
          hit = 1'b1;
        end
      end
      r_nxt.prdata = rdat;
      r_nxt.pslverr = ~hit | (paddr_i[ADDR_W-1:0] >> 12 != '0);
    end
  end

  // single state register
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      r_r <= '0;
      r_r.ilr <= {sbt_pkg::ILR_RST, sbt_pkg::ILR_RST};
      r_r.cnt <= {sbt_pkg::ILR_RST, sbt_pkg::ILR_RST};
      r_r.pre <= {sbt_pkg::PRE_RST, sbt_pkg::PRE_RST};
    end else begin
      r_r <= r_nxt;
    end
  end

  // outputs; zero-wait slave
  assign pready_o  = 1'b1;
  assign prdata_o  = r_r.prdata;
  assign pslverr_o = r_r.pslverr & psel_i & penable_i;
  assign trig_o    = r_r.trig;
  assign irq_o     = |(r_r.ris & r_r.imr);
  assign ccp_o     = r_r.pwm
                     ^ {r_r.ctl[sbt_pkg::CTL_STRIDE + sbt_pkg::CTL_PWML],
                        r_r.ctl[sbt_pkg::CTL_PWML]};
  assign ccp_oe_o  = pwm_m & {2{r_r.cfg == sbt_pkg::CFG_HALVES}};

  // checks watch half a, except capture, which the bench runs on half b
  chk_cfg_gate: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    r_r.cfg != sbt_pkg::CFG_HALVES && !ilr_wr[0] |=> $stable(r_r.cnt[0]))
    else $error("half counted outside 16-bit configuration");

  chk_reload_zero: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    to_ev[0] |=> r_r.cnt[0] == $past(r_r.ilr[0]))
    else $error("time-out did not reload interval value");

  chk_oneshot_stop: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    to_ev[0] && r_r.mode[0][1:0] == sbt_pkg::MODE_ONESHOT
    |=> !r_r.ctl[sbt_pkg::CTL_EN])
    else $error("one-shot half kept its enable");

  chk_flag_sticky: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    r_r.ris[sbt_pkg::IRQ_TO] && !(psel_i && penable_i && pwrite_i
    && addr == sbt_pkg::OFS_ICR) |=> r_r.ris[sbt_pkg::IRQ_TO])
    else $error("time-out flag dropped without clear");

  chk_trig_gate: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    trig_o[0] |-> $past(to_ev[0]) && $past(r_r.ctl[sbt_pkg::CTL_OTE]))
    else $error("trigger without enabled time-out");

  chk_ilr_load: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    ilr_wr[0] |=> r_r.cnt[0] == $past(pwdata_i[15:0]))
    else $error("interval write not taken by counter");

  chk_stall_hold: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    r_r.ctl[sbt_pkg::CTL_STALL] && !ilr_wr[0] |=> $stable(r_r.cnt[0]))
    else $error("stalled half changed its count");

  // edge counting leaves psc untouched, so mode 3 must be kept out here
  chk_prescale_wait: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    r_r.psc[0] != sbt_pkg::PSC_ZERO && r_r.cnt[0] != sbt_pkg::CNT_ZERO
    && !r_r.mode[0][sbt_pkg::MR_CMR] && !r_r.mode[0][sbt_pkg::MR_AMS]
    && r_r.mode[0][1:0] != sbt_pkg::MODE_CAPTURE
    && !ilr_wr[0] |=> $stable(r_r.cnt[0]))
    else $error("count stepped before prescale expired");

  chk_capture_val: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    cap_ev[1] |=> r_r.cap[1] == $past(r_r.cnt[1])
    && r_r.ris[sbt_pkg::IRQ_STRIDE + sbt_pkg::IRQ_CAP])
    else $error("capture value or flag wrong");

  chk_trig_fire: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    to_ev[0] && r_r.ctl[sbt_pkg::CTL_OTE] |=> trig_o[0])
    else $error("enabled time-out gave no trigger");

  chk_match_stop: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    $rose(r_r.ris[sbt_pkg::IRQ_MATCH])
    |-> !r_r.ctl[sbt_pkg::CTL_EN] && r_r.cnt[0] == r_r.ilr[0])
    else $error("edge-count match left half enabled or not reloaded");

endmodule

// [dv/sbt_pin_model.sv]
/*
  Edge source standing on the capture/compare pins of the timer.
  Assumes the bench resolves each pin against the timer's enable.
*/
`timescale 1ns/1ns
module sbt_pin_model #(
  parameter int HOLD = 4
) (
  input  wire logic clk_i,
  output      logic lvl_o
);
  initial lvl_o = 1'b0;

  // each level held HOLD clocks, above the two the sampler needs
  task automatic pulses(input int n);
    repeat (n) begin
      @(posedge clk_i) lvl_o <= ~lvl_o;
      repeat (HOLD - 1) @(posedge clk_i);
    end
    // let the input synchroniser catch up before anyone looks
    repeat (HOLD + 4) @(posedge clk_i);
  endtask
endmodule

// [dv/sbt_timer_bench.sv]
/*
  Self-checking bench for the dual-half timer, driven over APB.
  Assumes the zero-wait APB slave and register map of the package.
*/
`timescale 1ns/1ns
module sbt_timer_bench;
  localparam logic [31:0] EN    = 32'h1;
  localparam logic [31:0] STALL = 32'h1 << sbt_pkg::CTL_STALL;
  localparam logic [31:0] OTE   = 32'h1 << sbt_pkg::CTL_OTE;
  localparam logic [31:0] PWML  = 32'h1 << sbt_pkg::CTL_PWML;
  localparam logic [11:0] MODE_B = sbt_pkg::OFS_MODE + sbt_pkg::HALF_STRIDE;
  localparam logic [11:0] VAL_B  = sbt_pkg::OFS_VAL + sbt_pkg::HALF_STRIDE;
  logic        clk_i   = 1'b0;
  logic        rst_n_i = 1'b0;
  logic        psel    = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite  = 1'b0;
  logic [11:0] paddr   = 12'h000;
  logic [31:0] pwdata  = 32'h0;
  logic [31:0] prdata;
  logic [31:0] rd;
  logic [31:0] c1;
  logic        pready;
  logic        pslverr;
  logic        irq;
  logic        lvl;
  logic        err;
  logic [1:0]  ccp_o;
  logic [1:0]  ccp_oe;
  logic [1:0]  trig;
  logic [1:0]  pin;
  int          miscompares = 0;
  int          tests_run   = 0;
  int          cyc         = 0;
  int          n;

  initial forever #10 clk_i = ~clk_i;
  // pin wire: timer wins while it drives, else the edge source
  assign pin = (ccp_oe & ccp_o) | (~ccp_oe & {2{lvl}});

  sbt_timer uut (.clk_i(clk_i), .rst_n_i(rst_n_i), .psel_i(psel),
    .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr),
    .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
    .pslverr_o(pslverr), .ccp_i(pin), .ccp_o(ccp_o), .ccp_oe_o(ccp_oe),
    .trig_o(trig), .irq_o(irq));
  sbt_pin_model src (.clk_i(clk_i), .lvl_o(lvl));

  // one apb transfer; request held until pready seen high
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    @(posedge clk_i);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_i);
    penable <= 1'b1;
    do @(posedge clk_i); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // clocks until the next trigger pulse, capped at 500
  task automatic wait_trig(input int h);
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (trig[h] !== 1'b1 && n < 500);
  endtask

  task automatic count_high(input int h);
    n = 0;
    repeat (20) begin
      @(posedge clk_i);
      if (ccp_o[h] === 1'b1) n++;
    end
  endtask

  task automatic close_out();
    $display("compares %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  // a hang is cut short well beyond the thousand or so clocks needed
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 20000) begin
      miscompares++;
      close_out();
    end
  end

  initial begin : main
    logic [1:0] evt [3];
    int         expf [3];
    int         expv [3];
    evt = '{sbt_pkg::EVT_RISE, sbt_pkg::EVT_FALL, sbt_pkg::EVT_BOTH};
    expf = '{1, 0, 1};
    expv = '{4, 3, 4};
    repeat (10) @(posedge clk_i);
    rst_n_i <= 1'b1;
    apb(1'b0, sbt_pkg::OFS_ILR, 32'h0);
    chk(rd, 32'h0000ffff);
    apb(1'b0, sbt_pkg::OFS_PRE, 32'h0);
    chk(rd, 32'h0);
    apb(1'b0, 12'hffc, 32'h0);
    chk(32'(err), 32'h1);
    $display("test reset done");
    // periodic period with and without prescaler
    // enabled before the split config: the count must not move
    apb(1'b1, sbt_pkg::OFS_MODE, 32'h2);
    apb(1'b1, sbt_pkg::OFS_CTL, EN);
    repeat (5) @(posedge clk_i);
    apb(1'b0, sbt_pkg::OFS_VAL, 32'h0);
    chk(rd, 32'h0000ffff);
    apb(1'b1, sbt_pkg::OFS_CTL, 32'h0);
    apb(1'b1, sbt_pkg::OFS_CFG, 32'h4);
    for (int p = 0; p < 3; p += 2) begin
      apb(1'b1, sbt_pkg::OFS_PRE, 32'(p));
      apb(1'b1, sbt_pkg::OFS_ILR, 32'h3);
      apb(1'b1, sbt_pkg::OFS_CTL, EN | OTE);
      wait_trig(0);
      wait_trig(0);
      chk(32'(n), 32'(3 * (p + 1) + 1));
      apb(1'b1, sbt_pkg::OFS_CTL, 32'h0);
    end
    apb(1'b0, sbt_pkg::OFS_RIS, 32'h0);
    chk(rd, 32'h1);
    chk(32'(irq), 32'h0);
    apb(1'b1, sbt_pkg::OFS_IMR, 32'h1);
    @(posedge clk_i);
    chk(32'(irq), 32'h1);
    apb(1'b0, sbt_pkg::OFS_MIS, 32'h0);
    chk(rd, 32'h1);
    apb(1'b1, sbt_pkg::OFS_ICR, 32'h1);
    apb(1'b0, sbt_pkg::OFS_RIS, 32'h0);
    chk(rd, 32'h0);
    $display("test periodic done");
    // stall freezes, release lets it time out again
    apb(1'b1, sbt_pkg::OFS_CTL, EN | STALL);
    apb(1'b0, sbt_pkg::OFS_VAL, 32'h0);
    c1 = rd;
    repeat (7) @(posedge clk_i);
    apb(1'b0, sbt_pkg::OFS_VAL, 32'h0);
    chk(rd, c1);
    apb(1'b1, sbt_pkg::OFS_CTL, EN | OTE);
    wait_trig(0);
    chk(32'(n < 40), 32'h1);
    // one-shot without trigger enable
    apb(1'b1, sbt_pkg::OFS_CTL, 32'h0);
    apb(1'b1, sbt_pkg::OFS_MODE, 32'h1);
    apb(1'b1, sbt_pkg::OFS_ICR, 32'hff);
    apb(1'b1, sbt_pkg::OFS_CTL, EN);
    wait_trig(0);
    chk(32'(n), 32'd500);
    apb(1'b0, sbt_pkg::OFS_RIS, 32'h0);
    chk(rd, 32'h1);
    apb(1'b0, sbt_pkg::OFS_CTL, 32'h0);
    chk(rd, 32'h0);
    apb(1'b0, sbt_pkg::OFS_VAL, 32'h0);
    chk(rd, 32'h3);
    // interval rewrite while running
    apb(1'b1, sbt_pkg::OFS_MODE, 32'h2);
    apb(1'b1, sbt_pkg::OFS_ILR, 32'hff00);
    apb(1'b1, sbt_pkg::OFS_CTL, EN);
    apb(1'b1, sbt_pkg::OFS_ILR, 32'h100);
    apb(1'b0, sbt_pkg::OFS_VAL, 32'h0);
    chk(32'(rd <= 32'h100 && rd > 32'hf0), 32'h1);
    apb(1'b1, sbt_pkg::OFS_CTL, 32'h0);
    $display("test one-shot done");
    // edge count for the rise, fall and both codes; three toggles from low
    apb(1'b1, sbt_pkg::OFS_MODE, 32'h3);
    apb(1'b1, sbt_pkg::OFS_MATCH, 32'h2);
    for (int i = 0; i < 3; i++) begin
      apb(1'b1, sbt_pkg::OFS_ICR, 32'hff);
      apb(1'b1, sbt_pkg::OFS_ILR, 32'h4);
      apb(1'b1, sbt_pkg::OFS_CTL, EN | (32'(evt[i]) << sbt_pkg::CTL_EVT));
      src.pulses(3);
      apb(1'b0, sbt_pkg::OFS_RIS, 32'h0);
      chk(rd, 32'(expf[i]) << sbt_pkg::IRQ_MATCH);
      apb(1'b0, sbt_pkg::OFS_VAL, 32'h0);
      chk(rd, 32'(expv[i]));
      apb(1'b0, sbt_pkg::OFS_CTL, 32'h0);
      chk(rd & EN, 32'(expf[i] == 0));
      apb(1'b1, sbt_pkg::OFS_CTL, 32'h0);
      src.pulses(1);
    end
    $display("test edge count done");
    // edge time on half b from the reset interval
    apb(1'b1, sbt_pkg::OFS_ICR, 32'hff);
    apb(1'b1, MODE_B, 32'h7);
    apb(1'b1, sbt_pkg::OFS_CTL, EN << sbt_pkg::CTL_STRIDE);
    src.pulses(1);
    apb(1'b0, VAL_B, 32'h0);
    c1 = rd;
    chk(32'(c1 < 32'hffff), 32'h1);
    apb(1'b0, sbt_pkg::OFS_RIS, 32'h0);
    chk(rd, 32'h1 << (sbt_pkg::IRQ_STRIDE + sbt_pkg::IRQ_CAP));
    repeat (20) @(posedge clk_i);
    apb(1'b0, VAL_B, 32'h0);
    chk(rd, c1);
    src.pulses(2);
    apb(1'b0, VAL_B, 32'h0);
    chk(32'(rd < c1), 32'h1);
    apb(1'b0, sbt_pkg::OFS_CTL, 32'h0);
    chk(rd, EN << sbt_pkg::CTL_STRIDE);
    apb(1'b1, sbt_pkg::OFS_CTL, 32'h0);
    src.pulses(1);
    $display("test edge time done");
    // pwm with prescale still 2, which must not stretch the period
    apb(1'b1, sbt_pkg::OFS_ICR, 32'hff);
    apb(1'b1, sbt_pkg::OFS_MODE, (32'h1 << sbt_pkg::MR_AMS) | 32'h2);
    apb(1'b1, sbt_pkg::OFS_ILR, 32'h9);
    apb(1'b1, sbt_pkg::OFS_MATCH, 32'h2);
    apb(1'b1, sbt_pkg::OFS_CTL, EN);
    repeat (3) @(posedge clk_i);
    count_high(0);
    chk(32'(n), 32'd14);
    chk(32'(ccp_oe[0]), 32'h1);
    apb(1'b1, sbt_pkg::OFS_CTL, EN | PWML);
    repeat (3) @(posedge clk_i);
    count_high(0);
    chk(32'(n), 32'd6);
    apb(1'b0, sbt_pkg::OFS_RIS, 32'h0);
    chk(rd, 32'h0);
    $display("test pwm done");
    close_out();
  end
endmodule
